// ---- include/oag_defs.svh ----
// Constants for the operand address generator: opcodes, lengths, banks.
// Assumes inclusion by bare name from the package and design modules.
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH

// Number of addressing modes of the core
`define OAG_MODE_COUNT 28
// Opcodes, implied mode
`define OAG_OP_CLC 8'h18
`define OAG_OP_TXA 8'h8A
// Opcodes, immediate mode
`define OAG_OP_ADC_IMM 8'h69
`define OAG_OP_LDX_IMM 8'hA2
// Opcodes, accumulator mode
`define OAG_OP_ROL_ACC 8'h2A
// Opcodes, direct modes
`define OAG_OP_ADC_DIR 8'h65
`define OAG_OP_LDX_DIR 8'hA6
`define OAG_OP_CLB_DBIT 8'h14
`define OAG_OP_ADC_DIRX 8'h75
`define OAG_OP_LDY_DIRX 8'hB4
`define OAG_OP_LDX_DIRY 8'hB6
// Fill value for the upper byte of an 8-bit index destination
`define OAG_IDX_UPPER_FILL 8'h00
// Bank holding the direct page
`define OAG_BANK0 8'h00
// Instruction lengths in bytes
`define OAG_LEN_ONE 3'h1
`define OAG_LEN_TWO 3'h2
`define OAG_LEN_THREE 3'h3
`define OAG_LEN_FOUR 3'h4

`endif

// ---- include/oag_pkg.sv ----
// Types shared by the operand address generator modules.
// Assumes oag_defs.svh is on the include path.
`include "oag_defs.svh"

package oag_pkg;

   // All addressing modes of the core
   typedef enum logic [4:0] {
      MODE_IMPLIED, MODE_IMMEDIATE, MODE_ACCUMULATOR, MODE_DIRECT, MODE_DIRECT_BIT,
      MODE_DIRECT_X, MODE_DIRECT_Y, MODE_DIRECT_IND, MODE_DIRECT_X_IND, MODE_DIRECT_IND_Y,
      MODE_DIRECT_IND_LONG, MODE_DIRECT_IND_LONG_Y, MODE_ABSOLUTE, MODE_ABSOLUTE_BIT,
      MODE_ABSOLUTE_X, MODE_ABSOLUTE_Y, MODE_ABSOLUTE_LONG, MODE_ABSOLUTE_LONG_X,
      MODE_ABSOLUTE_IND, MODE_ABSOLUTE_IND_LONG, MODE_ABSOLUTE_X_IND, MODE_STACK,
      MODE_RELATIVE, MODE_DIRECT_BIT_REL, MODE_ABSOLUTE_BIT_REL, MODE_STACK_REL,
      MODE_STACK_REL_IND_Y, MODE_BLOCK_TRANSFER
   } oag_mode_t;

   // Internal register selector for implied transfers
   typedef enum logic [1:0] {REG_NONE, REG_ACC, REG_X, REG_Y} oag_reg_t;

   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EA, ST_DONE} oag_state_t;

   // Result of decoding one opcode
   typedef struct packed {
      oag_mode_t mode;
      logic known;
      logic idx_len;
      oag_reg_t src;
      oag_reg_t dst;
   } oag_decode_t;

endpackage : oag_pkg

// ---- include/oag_ea_if.sv ----
// Request and result path between the sequencer and the address adder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface oag_ea_if;
   logic req;
   logic [7:0] offset;
   logic [15:0] dpr;
   logic [15:0] index;
   logic use_index;
   logic valid;
   logic [23:0] ea;

   modport seq (output req, output offset, output dpr, output index, output use_index,
                input valid, input ea);
   modport adder (input req, input offset, input dpr, input index, input use_index,
                  output valid, output ea);
endinterface : oag_ea_if

// ---- hdl/oag_ea_adder.sv ----
// Registered adder forming bank-0 direct addresses with bank carry.
// Assumes one request at a time; result valid one cycle after request.
`timescale 1ns/1ns

module oag_ea_adder (
   input wire logic clk_in,
   input wire logic nrst_in,
   oag_ea_if.adder ea_if
);
   import oag_pkg::*;

   logic valid_reg, valid_next;
   logic [23:0] ea_reg, ea_next;

   // Three-term sum; carries above bit 15 become the bank number
   function automatic logic [23:0] direct_sum(input logic [7:0] ofs, input logic [15:0] dp,
                                              input logic [15:0] idx, input logic use_idx);
      logic [17:0] sum;
      sum = {10'h000, ofs} + {2'h0, dp} + (use_idx ? {2'h0, idx} : 18'h00000);
      return {6'h00, sum};
   endfunction : direct_sum

   ////////////////////////////////////////////////////////////////////////////
   // Next result
   always_comb begin
      valid_next = ea_if.req;
      ea_next = ea_reg;
      if (ea_if.req) begin
         ea_next = direct_sum(ea_if.offset, ea_if.dpr, ea_if.index, ea_if.use_index);
      end
   end

   // Result registers
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         valid_reg <= 1'b0;
         ea_reg <= 24'h000000;
      end else begin
         valid_reg <= valid_next;
         ea_reg <= ea_next;
      end
   end

   assign ea_if.valid = valid_reg;
   assign ea_if.ea = ea_reg;

endmodule : oag_ea_adder

// ---- hdl/oag_top.sv ----
// Operand address generator: fetches one instruction and resolves its operand.
// Assumes a byte-wide program memory answering each read with one valid pulse.
//
// Summary of operation
// - Mode type covers all 28 addressing modes
// - Implied opcodes select a register, no operands
// - Register transfer uses destination data length
// - 8-bit index destination gets zero upper byte
// - Immediate operand taken from instruction bytes
// - Instruction fetch carries across bank boundary
// - Accumulator mode operates on accumulator contents
// - Direct address is byte plus DPR, bank carry
// - Bit mask from byte three, plus byte four when the M flag is clear
// - Direct X address adds byte, DPR, X
// - Direct Y address adds byte, DPR, Y
// - Indexed sum overflow moves into bank 1/2
`timescale 1ns/1ns
`include "oag_defs.svh"

module oag_top #(
   parameter logic [7:0] SEB_DBIT_OPC = 8'h04,
   parameter logic [7:0] STX_DIRY_OPC = 8'h96
) (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic START_IN,
   input wire logic [23:0] PC_IN,
   input wire logic [15:0] DPR_IN,
   input wire logic [15:0] IDX_X_IN,
   input wire logic [15:0] IDX_Y_IN,
   input wire logic [15:0] ACC_IN,
   input wire logic M_FLAG_IN,
   input wire logic X_FLAG_IN,
   output logic MEM_RD_OUT,
   output logic [23:0] MEM_ADDR_OUT,
   input wire logic [7:0] MEM_RDATA_IN,
   input wire logic MEM_RVALID_IN,
   output logic BUSY_OUT,
   output logic DONE_OUT,
   output oag_pkg::oag_mode_t MODE_OUT,
   output logic UNKNOWN_OUT,
   output logic [7:0] OPCODE_OUT,
   output logic [23:0] EA_OUT,
   output logic EA_VALID_OUT,
   output logic [15:0] OPERAND_OUT,
   output logic [15:0] MASK_OUT,
   output logic LEN16_OUT,
   output oag_pkg::oag_reg_t DEST_REG_OUT,
   output logic [23:0] NEXT_PC_OUT
);
   import oag_pkg::*;

   oag_ea_if ea_if ();

   oag_state_t state_reg, state_next;
   logic [23:0] addr_reg, addr_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [2:0] len_reg, len_next;
   logic [7:0] b0_reg, b0_next, b1_reg, b1_next, b2_reg, b2_next, b3_reg, b3_next;
   logic [15:0] dpr_reg, dpr_next, x_reg, x_next, y_reg, y_next, acc_reg, acc_next;
   logic m_reg, m_next, xf_reg, xf_next;
   oag_mode_t mode_reg, mode_next;
   logic unknown_reg, unknown_next;
   logic [23:0] ea_reg, ea_next;
   logic ea_valid_reg, ea_valid_next;
   logic [15:0] operand_reg, operand_next, mask_reg, mask_next;
   logic len16_reg, len16_next;
   oag_reg_t dest_reg, dest_next;
   oag_decode_t dec_cur, dec_new;
   logic [2:0] len_new;
   logic last_byte;
   logic len16_cur;

   ////////////////////////////////////////////////////////////////////////////
   // Opcode decoder; unlisted opcodes are reported as unknown
   function automatic oag_decode_t decode(input logic [7:0] opc);
      oag_decode_t d;
      d = '{mode: MODE_IMPLIED, known: 1'b1, idx_len: 1'b0, src: REG_NONE, dst: REG_NONE};
      if (opc == `OAG_OP_CLC) begin
         d.dst = REG_NONE;
      end else if (opc == `OAG_OP_TXA) begin
         d.src = REG_X;
         d.dst = REG_ACC;
      end else if (opc == `OAG_OP_ADC_IMM) begin
         d.mode = MODE_IMMEDIATE;
      end else if (opc == `OAG_OP_LDX_IMM) begin
         d.mode = MODE_IMMEDIATE;
         d.idx_len = 1'b1;
         d.dst = REG_X;
      end else if (opc == `OAG_OP_ROL_ACC) begin
         d.mode = MODE_ACCUMULATOR;
         d.src = REG_ACC;
         d.dst = REG_ACC;
      end else if (opc == `OAG_OP_ADC_DIR) begin
         d.mode = MODE_DIRECT;
      end else if (opc == `OAG_OP_LDX_DIR) begin
         d.mode = MODE_DIRECT;
         d.idx_len = 1'b1;
         d.dst = REG_X;
      end else if (opc == `OAG_OP_CLB_DBIT || opc == SEB_DBIT_OPC) begin
         d.mode = MODE_DIRECT_BIT;
      end else if (opc == `OAG_OP_ADC_DIRX) begin
         d.mode = MODE_DIRECT_X;
      end else if (opc == `OAG_OP_LDY_DIRX) begin
         d.mode = MODE_DIRECT_X;
         d.idx_len = 1'b1;
         d.dst = REG_Y;
      end else if (opc == `OAG_OP_LDX_DIRY) begin
         d.mode = MODE_DIRECT_Y;
         d.idx_len = 1'b1;
         d.dst = REG_X;
      end else if (opc == STX_DIRY_OPC) begin
         d.mode = MODE_DIRECT_Y;
         d.idx_len = 1'b1;
         d.src = REG_X;
      end else begin
         d.known = 1'b0;
      end
      return d;
   endfunction : decode

   // Instruction length in bytes from mode and governing flags
   function automatic logic [2:0] instr_len(input oag_decode_t d, input logic m,
                                            input logic xf);
      logic flag;
      flag = d.idx_len ? xf : m;
      case (d.mode)
         MODE_IMMEDIATE: instr_len = flag ? `OAG_LEN_TWO : `OAG_LEN_THREE;
         MODE_DIRECT, MODE_DIRECT_X, MODE_DIRECT_Y: instr_len = `OAG_LEN_TWO;
         MODE_DIRECT_BIT: instr_len = m ? `OAG_LEN_THREE : `OAG_LEN_FOUR;
         default: instr_len = `OAG_LEN_ONE;
      endcase
   endfunction : instr_len

   // Register value by selector
   function automatic logic [15:0] reg_value(input oag_reg_t sel, input logic [15:0] a,
                                             input logic [15:0] x, input logic [15:0] y);
      case (sel)
         REG_ACC: reg_value = a;
         REG_X: reg_value = x;
         REG_Y: reg_value = y;
         default: reg_value = 16'h0000;
      endcase
   endfunction : reg_value

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the held opcode and of the byte arriving now
   assign dec_cur = decode(b0_reg);
   assign dec_new = decode(MEM_RDATA_IN);
   assign len_new = instr_len(dec_new, m_reg, xf_reg);
   assign last_byte = (cnt_reg == 3'h0) ? (len_new == `OAG_LEN_ONE) :
                      (cnt_reg + 3'h1 == len_reg);
   assign len16_cur = dec_cur.idx_len ? !xf_reg : !m_reg;

   // Adder request, issued when the last byte of a direct-type instruction lands
   assign ea_if.req = (state_reg == ST_FETCH) && MEM_RVALID_IN && last_byte &&
                      (cnt_reg != 3'h0) && (dec_cur.mode != MODE_IMMEDIATE);
   assign ea_if.offset = (cnt_reg == 3'h1) ? MEM_RDATA_IN : b1_reg;
   assign ea_if.dpr = dpr_reg;
   assign ea_if.index = (dec_cur.mode == MODE_DIRECT_Y) ? y_reg : x_reg;
   assign ea_if.use_index = (dec_cur.mode == MODE_DIRECT_X) ||
                            (dec_cur.mode == MODE_DIRECT_Y);

   oag_ea_adder u_adder (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .ea_if(ea_if)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and operand formation
   always_comb begin
      logic [15:0] src_val;
      logic [15:0] xfer;
      src_val = 16'h0000;
      xfer = 16'h0000;
      state_next = state_reg;
      addr_next = addr_reg;
      cnt_next = cnt_reg;
      len_next = len_reg;
      b0_next = b0_reg;
      b1_next = b1_reg;
      b2_next = b2_reg;
      b3_next = b3_reg;
      dpr_next = dpr_reg;
      x_next = x_reg;
      y_next = y_reg;
      acc_next = acc_reg;
      m_next = m_reg;
      xf_next = xf_reg;
      mode_next = mode_reg;
      unknown_next = unknown_reg;
      ea_next = ea_reg;
      ea_valid_next = ea_valid_reg;
      operand_next = operand_reg;
      mask_next = mask_reg;
      len16_next = len16_reg;
      dest_next = dest_reg;
      case (state_reg)
         ST_IDLE: begin
            if (START_IN) begin
               state_next = ST_FETCH;
               addr_next = PC_IN;
               cnt_next = 3'h0;
               dpr_next = DPR_IN;
               x_next = IDX_X_IN;
               y_next = IDX_Y_IN;
               acc_next = ACC_IN;
               m_next = M_FLAG_IN;
               xf_next = X_FLAG_IN;
            end
         end
         ST_FETCH: begin
            if (MEM_RVALID_IN) begin
               addr_next = addr_reg + 24'h000001;
               cnt_next = cnt_reg + 3'h1;
               case (cnt_reg)
                  3'h0: begin
                     b0_next = MEM_RDATA_IN;
                     len_next = len_new;
                  end
                  3'h1: b1_next = MEM_RDATA_IN;
                  3'h2: b2_next = MEM_RDATA_IN;
                  default: b3_next = MEM_RDATA_IN;
               endcase
               if (last_byte) state_next = ea_if.req ? ST_EA : ST_DONE;
            end
         end
         ST_EA: if (ea_if.valid) state_next = ST_DONE;
         default: state_next = ST_IDLE;
      endcase
      // Results are formed as the instruction completes
      if (state_next == ST_DONE && state_reg != ST_DONE) begin
         mode_next = dec_cur.mode;
         unknown_next = !dec_cur.known;
         dest_next = dec_cur.dst;
         len16_next = len16_cur;
         ea_valid_next = 1'b0;
         mask_next = 16'h0000;
         operand_next = 16'h0000;
         if (cnt_reg == 3'h0) begin
            mode_next = dec_new.mode;
            unknown_next = !dec_new.known;
            dest_next = dec_new.dst;
            len16_next = dec_new.idx_len ? !xf_reg : !m_reg;
            src_val = reg_value(dec_new.src, acc_reg, x_reg, y_reg);
            if (dec_new.dst == REG_ACC) begin
               xfer = m_reg ? {acc_reg[15:8], src_val[7:0]} : src_val;
            end else if (dec_new.dst != REG_NONE) begin
               xfer = xf_reg ? {`OAG_IDX_UPPER_FILL, src_val[7:0]} : src_val;
            end
            operand_next = xfer;
         end else if (dec_cur.mode == MODE_IMMEDIATE) begin
            operand_next = len16_cur ? {MEM_RDATA_IN, b1_reg} : {8'h00, MEM_RDATA_IN};
         end
      end
      if (state_reg == ST_EA && ea_if.valid) begin
         ea_next = ea_if.ea;
         ea_valid_next = 1'b1;
         mask_next = (dec_cur.mode == MODE_DIRECT_BIT) ?
                     (m_reg ? {8'h00, b2_reg} : {b3_reg, b2_reg}) : 16'h0000;
      end
   end

   // Sequencer registers
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         state_reg <= ST_IDLE;
         addr_reg <= 24'h000000;
         cnt_reg <= 3'h0;
         len_reg <= `OAG_LEN_ONE;
         b0_reg <= 8'h00;
         b1_reg <= 8'h00;
         b2_reg <= 8'h00;
         b3_reg <= 8'h00;
         dpr_reg <= 16'h0000;
         x_reg <= 16'h0000;
         y_reg <= 16'h0000;
         acc_reg <= 16'h0000;
         m_reg <= 1'b1;
         xf_reg <= 1'b1;
         mode_reg <= MODE_IMPLIED;
         unknown_reg <= 1'b0;
         ea_reg <= 24'h000000;
         ea_valid_reg <= 1'b0;
         operand_reg <= 16'h0000;
         mask_reg <= 16'h0000;
         len16_reg <= 1'b0;
         dest_reg <= REG_NONE;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         cnt_reg <= cnt_next;
         len_reg <= len_next;
         b0_reg <= b0_next;
         b1_reg <= b1_next;
         b2_reg <= b2_next;
         b3_reg <= b3_next;
         dpr_reg <= dpr_next;
         x_reg <= x_next;
         y_reg <= y_next;
         acc_reg <= acc_next;
         m_reg <= m_next;
         xf_reg <= xf_next;
         mode_reg <= mode_next;
         unknown_reg <= unknown_next;
         ea_reg <= ea_next;
         ea_valid_reg <= ea_valid_next;
         operand_reg <= operand_next;
         mask_reg <= mask_next;
         len16_reg <= len16_next;
         dest_reg <= dest_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign MEM_RD_OUT = (state_reg == ST_FETCH);
   assign MEM_ADDR_OUT = addr_reg;
   assign BUSY_OUT = (state_reg != ST_IDLE);
   assign DONE_OUT = (state_reg == ST_DONE);
   assign MODE_OUT = mode_reg;
   assign UNKNOWN_OUT = unknown_reg;
   assign OPCODE_OUT = b0_reg;
   assign EA_OUT = ea_reg;
   assign EA_VALID_OUT = ea_valid_reg;
   assign OPERAND_OUT = operand_reg;
   assign MASK_OUT = mask_reg;
   assign LEN16_OUT = len16_reg;
   assign DEST_REG_OUT = dest_reg;
   assign NEXT_PC_OUT = addr_reg;

endmodule : oag_top

// ---- verif/oag_mem_model.sv ----
// Byte-wide program memory model facing the operand address generator.
// Assumes requests are held high until a byte is handed back.
`timescale 1ns/1ns

module oag_mem_model (
   input wire logic clk_in,
   input wire logic rd_in,
   input wire logic [23:0] addr_in,
   input wire logic [1:0] wait_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out
);
   // Sparse byte store, filled by the bench
   logic [7:0] mem [logic [23:0]];
   logic [1:0] cnt_reg = 2'h0;

   initial begin
      rdata_out = 8'h00;
      rvalid_out = 1'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer after wait_in idle cycles; data toggles when not valid
   always @(negedge clk_in) begin
      if (rd_in === 1'h1 && cnt_reg >= wait_in) begin
         rvalid_out <= 1'h1;
         rdata_out <= mem[addr_in];
         cnt_reg <= 2'h0;
      end else begin
         rvalid_out <= 1'h0;
         rdata_out <= ~rdata_out; // No stale byte on the bus
         if (rd_in === 1'h1) begin
            cnt_reg <= cnt_reg + 2'h1;
         end
      end
   end
endmodule : oag_mem_model

// ---- verif/oag_top_chk.sv ----
// Port-level checks of the operand address generator.
// Assumes oag_pkg is compiled first; bound into oag_top below.
`timescale 1ns/1ns

module oag_top_chk
   import oag_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic START_IN,
   input wire logic [23:0] PC_IN,
   input wire logic MEM_RD_OUT,
   input wire logic [23:0] MEM_ADDR_OUT,
   input wire logic MEM_RVALID_IN,
   input wire logic BUSY_OUT,
   input wire logic DONE_OUT,
   input wire oag_pkg::oag_mode_t MODE_OUT,
   input wire logic UNKNOWN_OUT,
   input wire logic [23:0] EA_OUT,
   input wire logic EA_VALID_OUT,
   input wire logic [15:0] OPERAND_OUT,
   input wire logic [15:0] MASK_OUT,
   input wire logic LEN16_OUT
);
   // One clock, one reset for every check
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);

   ////////////////////////////////////////////////////////////////////////
   // Steps of an instruction
   sequence s_taken;
      !BUSY_OUT && START_IN;
   endsequence
   sequence s_byte;
      MEM_RD_OUT && MEM_RVALID_IN;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Fetch and sequencing
   a_start_fetch: assert property (s_taken |=> BUSY_OUT && MEM_RD_OUT
      && MEM_ADDR_OUT == $past(PC_IN)) else $error("first fetch not at start address");
   a_addr_step: assert property (s_byte ##1 MEM_RD_OUT |->
      MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 24'h000001) else $error("fetch address skipped");
   a_done_idle: assert property (DONE_OUT |-> BUSY_OUT && !MEM_RD_OUT
      ##1 !DONE_OUT && !BUSY_OUT) else $error("done not a single pulse");
   a_result_hold: assert property (!DONE_OUT |-> $stable(EA_OUT)
      && $stable(MODE_OUT) && $stable(OPERAND_OUT)) else $error("result moved outside done");

   ////////////////////////////////////////////////////////////////////////
   // Results at completion
   a_ea_valid: assert property (DONE_OUT |-> EA_VALID_OUT == (MODE_OUT inside
      {MODE_DIRECT, MODE_DIRECT_BIT, MODE_DIRECT_X, MODE_DIRECT_Y})) else $error("ea valid wrong");
   a_ea_bank: assert property (DONE_OUT && EA_VALID_OUT |->
      EA_OUT[23:18] == 6'h00 && EA_OUT[17:16] != 2'h3) else $error("bank beyond two");
   a_dir_bank: assert property (DONE_OUT && MODE_OUT inside {MODE_DIRECT,
      MODE_DIRECT_BIT} |-> !EA_OUT[17]) else $error("direct bank beyond one");
   a_mask_only: assert property (DONE_OUT && MODE_OUT != MODE_DIRECT_BIT |->
      MASK_OUT == 16'h0000) else $error("mask outside bit mode");
   a_mask_short: assert property (DONE_OUT && MODE_OUT == MODE_DIRECT_BIT && !LEN16_OUT
      |-> MASK_OUT[15:8] == 8'h00) else $error("short mask has upper byte");
   a_imm_short: assert property (DONE_OUT && MODE_OUT == MODE_IMMEDIATE && !LEN16_OUT
      |-> OPERAND_OUT[15:8] == 8'h00) else $error("short immediate has upper byte");
   a_dir_operand: assert property (DONE_OUT && EA_VALID_OUT |->
      OPERAND_OUT == 16'h0000) else $error("operand set in direct mode");
   a_unknown_impl: assert property (DONE_OUT && UNKNOWN_OUT |->
      MODE_OUT == MODE_IMPLIED) else $error("unknown opcode not implied");
endmodule : oag_top_chk

bind oag_top oag_top_chk u_oag_top_chk (
   .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .START_IN(START_IN), .PC_IN(PC_IN),
   .MEM_RD_OUT(MEM_RD_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RVALID_IN(MEM_RVALID_IN),
   .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .MODE_OUT(MODE_OUT),
   .UNKNOWN_OUT(UNKNOWN_OUT), .EA_OUT(EA_OUT), .EA_VALID_OUT(EA_VALID_OUT),
   .OPERAND_OUT(OPERAND_OUT), .MASK_OUT(MASK_OUT), .LEN16_OUT(LEN16_OUT)
);

// ---- verif/oag_top_tb.sv ----
// Self-checking bench of the operand address generator.
// Assumes oag_pkg, the design and the memory model are compiled first.
`timescale 1ns/1ns

module oag_top_tb;
   import oag_pkg::*;

   typedef struct {
      oag_mode_t mode; int n; logic [23:0] ea; logic ev; logic [15:0] opnd;
      logic [15:0] mask; logic l16; oag_reg_t dst; logic dk; logic unk;
   } oag_exp_t;

   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic start = 1'h0;
   logic m_f = 1'h1;
   logic x_f = 1'h1;
   logic [23:0] pc = 24'h000000;
   logic [15:0] dpr = 16'h0000, ix = 16'h0000, iy = 16'h0000, acc = 16'h0000;
   logic [1:0] wait_cyc = 2'h0;
   logic [7:0] rdata, opc;
   logic rvalid, rd, busy, done, unk, ev, l16;
   logic [23:0] addr, ea, npc;
   logic [15:0] opnd, mask;
   oag_mode_t mode;
   oag_reg_t dst;
   logic [31:0] seed = 32'hC398;
   int err_total = 0;
   int samples_checked = 0;
   logic [7:0] ops [14] = '{8'h18, 8'h8A, 8'h69, 8'hA2, 8'h2A, 8'h65, 8'hA6,
      8'h14, 8'h04, 8'h75, 8'hB4, 8'hB6, 8'h96, 8'hFF};

   // 50 MHz clock
   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Design and memory
   oag_top u_oag_top (
      .CLK_IN(clk), .NRST_IN(nrst), .START_IN(start), .PC_IN(pc), .DPR_IN(dpr),
      .IDX_X_IN(ix), .IDX_Y_IN(iy), .ACC_IN(acc), .M_FLAG_IN(m_f), .X_FLAG_IN(x_f),
      .MEM_RD_OUT(rd), .MEM_ADDR_OUT(addr), .MEM_RDATA_IN(rdata), .MEM_RVALID_IN(rvalid),
      .BUSY_OUT(busy), .DONE_OUT(done), .MODE_OUT(mode), .UNKNOWN_OUT(unk),
      .OPCODE_OUT(opc), .EA_OUT(ea), .EA_VALID_OUT(ev), .OPERAND_OUT(opnd),
      .MASK_OUT(mask), .LEN16_OUT(l16), .DEST_REG_OUT(dst), .NEXT_PC_OUT(npc)
   );
   oag_mem_model u_oag_mem_model (.clk_in(clk), .rd_in(rd), .addr_in(addr),
      .wait_in(wait_cyc), .rdata_out(rdata), .rvalid_out(rvalid));

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
      end
   endtask : check

   // Expected results of one instruction
   function automatic oag_exp_t exp_of(input logic [31:0] by, input logic [63:0] rg,
         input logic [1:0] fl2);
      oag_exp_t e;
      logic fl;
      logic [17:0] s;
      logic [7:0] op;
      op = by[31:24];
      e = '{MODE_IMPLIED, 1, 24'h000000, 1'h0, 16'h0000, 16'h0000, 1'h0, REG_NONE, 1'h0, 1'h0};
      fl = (op inside {8'hA2, 8'hA6, 8'hB4, 8'hB6, 8'h96}) ? fl2[0] : fl2[1];
      case (op)
         8'h18, 8'h8A: e.mode = MODE_IMPLIED;
         8'h69, 8'hA2: e.mode = MODE_IMMEDIATE;
         8'h2A: e.mode = MODE_ACCUMULATOR;
         8'h65, 8'hA6: e.mode = MODE_DIRECT;
         8'h14, 8'h04: e.mode = MODE_DIRECT_BIT;
         8'h75, 8'hB4: e.mode = MODE_DIRECT_X;
         8'hB6, 8'h96: e.mode = MODE_DIRECT_Y;
         default: e.unk = 1'h1;
      endcase
      e.l16 = !fl;
      e.ev = e.mode inside {MODE_DIRECT, MODE_DIRECT_BIT, MODE_DIRECT_X, MODE_DIRECT_Y};
      e.n = e.mode == MODE_IMMEDIATE ? (fl ? 2 : 3) :
         e.mode == MODE_DIRECT_BIT ? (fl2[1] ? 3 : 4) : e.ev ? 2 : 1;
      s = rg[63:48] + by[23:16] + (e.mode == MODE_DIRECT_X ? rg[47:32] :
         e.mode == MODE_DIRECT_Y ? rg[31:16] : 16'h0000);
      e.ea = {6'h00, s};
      e.mask = e.mode != MODE_DIRECT_BIT ? 16'h0000 :
         fl2[1] ? {8'h00, by[15:8]} : {by[7:0], by[15:8]};
      e.opnd = e.mode == MODE_IMMEDIATE ? (fl ? {8'h00, by[23:16]} : {by[15:8],
         by[23:16]}) : op == 8'h2A ? rg[15:0] : op != 8'h8A ? 16'h0000 :
         fl2[1] ? {rg[15:8], rg[39:32]} : rg[47:32];
      e.dst = op == 8'h8A ? REG_ACC : op inside {8'hA2, 8'hA6, 8'hB6} ? REG_X :
         op == 8'hB4 ? REG_Y : REG_NONE;
      e.dk = op inside {8'h18, 8'h8A, 8'hA2, 8'hA6, 8'hB4, 8'hB6, 8'h96};
      return e;
   endfunction : exp_of

   // One instruction: bytes {op,b1,b2,b3}, regs {dpr,x,y,acc}, flags {m,x}
   task automatic run(input logic [23:0] p, input logic [31:0] by, input logic [63:0] rg,
         input logic [1:0] fl2);
      oag_exp_t e;
      int k;
      e = exp_of(by, rg, fl2);
      for (int i = 0; i < 4; i++) begin
         u_oag_mem_model.mem[p + 24'(i)] = by[31 - 8 * i -: 8];
      end
      @(negedge clk);
      {pc, dpr, ix, iy, acc, m_f, x_f, start} = {p, rg, fl2, 1'h1};
      @(negedge clk);
      {pc, dpr, ix, iy, acc, m_f, x_f} = ~{p, rg, fl2}; // Ignored while busy
      @(negedge clk);
      start = 1'h0;
      k = 0;
      while (done !== 1'h1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      check(k < 40, 1'h1);
      check(mode, e.mode);
      check(unk, e.unk);
      check(opc, by[31:24]);
      check(opnd, e.opnd);
      check(mask, e.mask);
      check(l16, e.l16);
      check(npc, 24'(p + e.n));
      check(ev, e.ev);
      if (e.ev) check(ea, e.ea);
      if (e.dk) check(dst, e.dst);
      @(negedge clk);
      check({done, busy}, 2'h0);
   endtask : run

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////
   // Corner cases, then random instructions with random memory waits
   initial begin
      logic [31:0] r, q;
      logic [63:0] rg;
      repeat (4) @(negedge clk);
      nrst = 1'h1;
      check(32'(mode.num()), 32'd28);
      run(24'h001000, 32'h18000000, 64'h0, 2'h3);
      run(24'h001001, 32'h8A000000, 64'h0000567800001234, 2'h2);
      run(24'h001002, 32'h8A000000, 64'h0000007800001234, 2'h1);
      run(24'h002000, 32'h69A50000, 64'h0, 2'h3);
      run(24'h002010, 32'h69B7A500, 64'h0, 2'h0);
      run(24'h002020, 32'hA2A50000, 64'h0, 2'h1);
      run(24'h00FFFF, 32'hA2B7A500, 64'h0, 2'h2);
      run(24'h003000, 32'h2A000000, 64'h000000000000ABCD, 2'h3);
      run(24'h003001, 32'h2A000000, 64'h000000000000ABCD, 2'h0);
      run(24'h004000, 32'h65200000, 64'hFFF0000000000000, 2'h3);
      run(24'h004010, 32'hA6020000, 64'h0100000000000000, 2'h0);
      run(24'h005000, 32'h14045A00, 64'hFFFE000000000000, 2'h3);
      run(24'h005010, 32'h1404A55A, 64'h0, 2'h0);
      run(24'h005020, 32'h04FF0FF0, 64'h0, 2'h0);
      run(24'h006000, 32'h751E0000, 64'hFFF0002000000000, 2'h0);
      run(24'h006010, 32'hB4FF0000, 64'hFFFFFFFF00000000, 2'h0);
      run(24'h007000, 32'hB6020000, 64'h0010000000F00000, 2'h1);
      run(24'h007010, 32'h96FF0000, 64'hFFFF0000FFFF0000, 2'h0);
      run(24'h008000, 32'hFF000000, 64'h0, 2'h3);
      for (int i = 0; i < 48; i++) begin
         seed = xs(seed);
         r = seed;
         seed = xs(seed);
         q = seed;
         seed = xs(seed);
         rg = {q, seed};
         if (r[2]) {rg[47:40], rg[31:24]} = 16'h0000;
         wait_cyc = r[1:0];
         run(r[31:8], {ops[q % 14], q[23:0]}, rg, r[3:2]);
      end
      close_out();
   end

   // Watchdog, well beyond the longest expected run
   initial begin
      #400000;
      err_total++;
      close_out();
   end
endmodule : oag_top_tb
